// ==== hdl/sesp_pkg.sv ====
// Constants for the serial EEPROM status and opcode front end
package sesp_pkg;
	// Opcode patterns after the don't-care bit 3 is masked
	localparam logic [7:0] OPC_MASK      = 8'hF7;
	localparam logic [7:0] OPC_SET_WL    = 8'h06;
	localparam logic [7:0] OPC_CLR_WL    = 8'h04;
	localparam logic [7:0] OPC_STAT_RD   = 8'h05;
	localparam logic [7:0] OPC_STAT_WR   = 8'h01;
	localparam logic [7:0] OPC_ARR_RD    = 8'h03;
	localparam logic [7:0] OPC_ARR_WR    = 8'h02;
	localparam logic [7:0] OPC_ID_RD     = 8'h83;
	localparam logic [7:0] OPC_ID_WR     = 8'h82;
	// Status register field positions and busy read value
	localparam int        SR_BUSY       = 0;
	localparam int        SR_WEL        = 1;
	localparam int        SR_BP_LO      = 2;
	localparam int        SR_BP_HI      = 3;
	localparam int        SR_HPE        = 7;
	localparam logic [7:0] SR_BUSY_VAL  = 8'hFF;
	// Block protection lower bounds and array top address
	localparam logic [15:0] BP_Q1_BASE  = 16'h3000;
	localparam logic [15:0] BP_Q2_BASE  = 16'h2000;
	localparam logic [15:0] BP_ALL_BASE = 16'h0000;
	localparam logic [15:0] ARR_TOP     = 16'h3FFF;
	// Address bit that selects lock instructions on the ID codes
	localparam int        ID_LOCK_BIT   = 10;
	// Bit counts within a frame
	localparam logic [5:0] CNT_OPC_END  = 6'h08;
	localparam logic [5:0] CNT_SR_END   = 6'h10;
	localparam logic [5:0] CNT_ADR_END  = 6'h18;
	localparam logic [5:0] CNT_DAT_END  = 6'h20;
	localparam logic [5:0] CNT_MAX      = 6'h3F;
	// Internal write cycle length in reference clocks (shortened model)
	localparam logic [15:0] WR_CYCLES   = 16'h0100;

	function automatic logic [7:0] sesp_opc(input logic [7:0] b);
		return b & OPC_MASK;
	endfunction
endpackage

// ==== hdl/sesp_sync.sv ====
// Two-flop level synchroniser
`timescale 1ns/1ps
module sesp_sync (
	input  wire logic i_clk,
	input  wire logic i_reset,
	input  wire logic i_d,
	output logic      o_q
);
	logic meta_q;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			meta_q <= 1'b0;
			o_q    <= 1'b0;
		end else begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end
endmodule // sesp_sync

// ==== hdl/sesp_core.sv ====
// Serial EEPROM instruction front end and protection status register
//
// Behaviour
// - Status register read-only under protection or latch clear
// - Bit 0 busy; only status read while busy
// - Bit 1 write latch; clear blocks all writes
// - Reset clears the write latch
// - Disable, status write, array write clear latch
// - Bits 2,3 block protection, independent settings
// - Protection pair maps to top address ranges
// - Protection bits held, zero when delivered
// - Bits 4-6 not stored, read zero idle
// - Bit 7 with low pin enables hw protection
// - Enable bit not cleared while pin low
// - All bits read one during write cycle
// - Select low starts; input sampled on rise
// - Eight-bit opcode; output changes on falls
// - Everything shifted most significant bit first
// - Return to standby after operation completes
// - Decode set and clear latch opcodes
// - Decode status read and status write
// - Decode array write with address
// - Decode identification page write
// - Address bit 10 selects ID or lock
// - Status write needs latch and no protection
`timescale 1ns/1ps
module sesp_core (
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset,
	input  wire logic        i_sck,
	input  wire logic        i_cs_n,
	input  wire logic        i_si,
	input  wire logic        i_wp_n,
	output logic             o_so,
	output logic             o_so_oe,
	output logic [7:0]       o_status,
	output logic             o_arr_wr_req,
	output logic             o_id_wr_req,
	output logic [15:0]      o_addr,
	output logic             o_addr_prot
);
	// Link side, clocked by the serial clock and by select rise
	logic [5:0]  bit_cnt_q;
	logic [7:0]  opc_q;
	logic [15:0] adr_q;
	logic [7:0]  dat_q;
	logic [7:0]  sr_snap_q;
	logic        so_q;
	logic        oe_q;
	logic        done_tgl_q;
	logic [7:0]  frm_opc_q;
	logic [15:0] frm_adr_q;
	logic [7:0]  frm_dat_q;
	logic        frm_ok_q;
	logic [7:0]  opc_now;
	logic [7:0]  sr_view_link;

	// Reference side
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_BUSY = 3'b100
	} sesp_state_t;
	sesp_state_t st_q;
	logic        tgl_s;
	logic        tgl_seen_q;
	logic        wp_s;
	logic        wel_q;
	logic [1:0]  bp_q;
	logic        hpe_q;
	logic [15:0] wr_cnt_q;
	logic [7:0]  status_q;
	logic        arr_wr_q;
	logic        id_wr_q;
	logic [15:0] addr_q;
	logic        prot_q;
	logic        hw_prot;
	logic [7:0]  c_opc;
	logic [7:0]  status_d;

	function automatic logic addr_protected(input logic [1:0] bp,
		input logic [15:0] a);
		logic [15:0] base;
		base = sesp_pkg::BP_ALL_BASE;
		case (bp)
			2'h1:    base = sesp_pkg::BP_Q1_BASE;
			2'h2:    base = sesp_pkg::BP_Q2_BASE;
			default: base = sesp_pkg::BP_ALL_BASE;
		endcase
		return (bp != 2'h0) && (a[13:0] >= base[13:0]) &&
			(a[13:0] <= sesp_pkg::ARR_TOP[13:0]);
	endfunction

	// Status view crosses as a multi-bit word; it changes after frames and
	// at the end of a write cycle, which can coincide with the snapshot at opcode end.
	assign sr_view_link = status_q;
	assign opc_now = sesp_pkg::sesp_opc({opc_q[6:0], i_si});

	// sample on rising edge, frame reset by select high
	always_ff @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			bit_cnt_q <= '0;
			opc_q     <= '0;
			adr_q     <= '0;
			dat_q     <= '0;
		end else begin
			if (bit_cnt_q != sesp_pkg::CNT_MAX)
				bit_cnt_q <= bit_cnt_q + 6'h01;
			if (bit_cnt_q < sesp_pkg::CNT_OPC_END)
				opc_q <= {opc_q[6:0], i_si};
			else if (bit_cnt_q < sesp_pkg::CNT_ADR_END)
				adr_q <= {adr_q[14:0], i_si};
			else if (bit_cnt_q < sesp_pkg::CNT_DAT_END)
				dat_q <= {dat_q[6:0], i_si};
			if (bit_cnt_q < sesp_pkg::CNT_SR_END &&
				bit_cnt_q >= sesp_pkg::CNT_OPC_END)
				dat_q <= {dat_q[6:0], i_si};
		end
	end

	// Status snapshot taken as the last opcode bit arrives
	always_ff @(posedge i_sck) begin
		if (bit_cnt_q == sesp_pkg::CNT_OPC_END - 6'h01)
			sr_snap_q <= sr_view_link;
		else if (bit_cnt_q >= sesp_pkg::CNT_OPC_END)
			sr_snap_q <= {sr_snap_q[6:0], sr_snap_q[7]};
	end

	// output changes on falling edge, status read repeats
	always_ff @(negedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			so_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (bit_cnt_q >= sesp_pkg::CNT_OPC_END &&
			sesp_pkg::sesp_opc(opc_q) == sesp_pkg::OPC_STAT_RD) begin
			so_q <= sr_snap_q[7];
			oe_q <= 1'b1;
		end
	end
	assign o_so    = so_q;
	assign o_so_oe = oe_q;

	// frame capture on select rise, handed over by toggle
	always_ff @(posedge i_cs_n) begin
		frm_opc_q  <= opc_q;
		frm_adr_q  <= adr_q;
		frm_dat_q  <= dat_q;
		frm_ok_q   <= (bit_cnt_q == sesp_pkg::CNT_OPC_END) ||
			(bit_cnt_q == sesp_pkg::CNT_SR_END) ||
			(bit_cnt_q >= sesp_pkg::CNT_DAT_END &&
			bit_cnt_q[2:0] == 3'h0);
	end

	// Toggle needs a known start, or the reference side never sees a frame
	always_ff @(posedge i_cs_n or posedge i_reset) begin
		if (i_reset)
			done_tgl_q <= 1'b0;
		else
			done_tgl_q <= ~done_tgl_q;
	end

	sesp_sync u_tgl (
		.i_clk  (i_ref_clk),
		.i_reset(i_reset),
		.i_d    (done_tgl_q),
		.o_q    (tgl_s)
	);
	sesp_sync u_wp (
		.i_clk  (i_ref_clk),
		.i_reset(i_reset),
		.i_d    (i_wp_n),
		.o_q    (wp_s)
	);

	// hardware protection from enable bit and low pin
	assign hw_prot = hpe_q & ~wp_s;
	assign c_opc   = sesp_pkg::sesp_opc(frm_opc_q);

	// sequencer returns to idle after the write cycle
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			st_q       <= ST_IDLE;
			tgl_seen_q <= 1'b0;
			wr_cnt_q   <= '0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (tgl_s != tgl_seen_q) begin
						tgl_seen_q <= tgl_s;
						st_q       <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					st_q <= (arr_wr_q | id_wr_q | sr_wr_go()) ?
						ST_BUSY : ST_IDLE;
					wr_cnt_q <= sesp_pkg::WR_CYCLES;
				end
				ST_BUSY: begin
					if (tgl_s != tgl_seen_q)
						tgl_seen_q <= tgl_s;
					if (wr_cnt_q == 16'h0001)
						st_q <= ST_IDLE;
					wr_cnt_q <= wr_cnt_q - 16'h0001;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	function automatic logic sr_wr_go();
		// status write gated by latch and protection
		return c_opc == sesp_pkg::OPC_STAT_WR && frm_ok_q &&
			wel_q && !hw_prot;
	endfunction

	// Array and ID write requests, issued in the exec cycle
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			arr_wr_q <= 1'b0;
			id_wr_q  <= 1'b0;
			addr_q   <= '0;
		end else if (st_q == ST_IDLE && tgl_s != tgl_seen_q) begin
			addr_q <= frm_adr_q;
			// array write needs latch and unprotected address
			arr_wr_q <= c_opc == sesp_pkg::OPC_ARR_WR && frm_ok_q &&
				wel_q && !addr_protected(bp_q, frm_adr_q);
			// ID page write when address bit 10 clear
			id_wr_q <= c_opc == sesp_pkg::OPC_ID_WR && frm_ok_q &&
				wel_q && !frm_adr_q[sesp_pkg::ID_LOCK_BIT];
		end else if (st_q != ST_IDLE) begin
			arr_wr_q <= arr_wr_q & (st_q == ST_EXEC);
			id_wr_q  <= id_wr_q & (st_q == ST_EXEC);
			if (st_q == ST_BUSY) begin
				arr_wr_q <= 1'b0;
				id_wr_q  <= 1'b0;
			end
		end
	end

	// Flag follows protection changes, not only new frames
	always_ff @(posedge i_ref_clk) begin
		if (i_reset)
			prot_q <= 1'b0;
		else if (st_q == ST_IDLE && tgl_s != tgl_seen_q)
			prot_q <= addr_protected(bp_q, frm_adr_q);
		else
			prot_q <= addr_protected(bp_q, addr_q);
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset)
			wel_q <= 1'b0;
		else if (st_q == ST_EXEC) begin
			if (c_opc == sesp_pkg::OPC_SET_WL)
				wel_q <= 1'b1;
			else if (c_opc == sesp_pkg::OPC_CLR_WL)
				wel_q <= 1'b0;
		end else if (st_q == ST_BUSY && wr_cnt_q == 16'h0001)
			wel_q <= 1'b0;
	end

	// protection fields, updated in the exec cycle at write start
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			bp_q  <= 2'h0;
			hpe_q <= 1'b0;
		end else if (st_q == ST_EXEC && sr_wr_go()) begin
			bp_q <= {frm_dat_q[sesp_pkg::SR_BP_HI],
				frm_dat_q[sesp_pkg::SR_BP_LO]};
			if (!(hpe_q && !wp_s && !frm_dat_q[sesp_pkg::SR_HPE]))
				hpe_q <= frm_dat_q[sesp_pkg::SR_HPE];
		end
	end

	always_comb begin
		status_d = '0;
		status_d[sesp_pkg::SR_WEL]    = wel_q;
		status_d[sesp_pkg::SR_BP_LO]  = bp_q[0];
		status_d[sesp_pkg::SR_BP_HI]  = bp_q[1];
		status_d[sesp_pkg::SR_HPE]    = hpe_q;
		if (st_q == ST_BUSY)
			status_d = sesp_pkg::SR_BUSY_VAL;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset)
			status_q <= '0;
		else
			status_q <= status_d;
	end

	assign o_status     = status_q;
	assign o_arr_wr_req = arr_wr_q;
	assign o_id_wr_req  = id_wr_q;
	assign o_addr       = addr_q;
	assign o_addr_prot  = prot_q;
endmodule // sesp_core

// ==== tb/sesp_core_properties.sv ====
// Port checks for the status and opcode front end
`timescale 1ns/1ps
module sesp_core_properties (
	input wire logic        i_ref_clk,
	input wire logic        i_reset,
	input wire logic        i_sck,
	input wire logic        i_cs_n,
	input wire logic        i_si,
	input wire logic        i_wp_n,
	input wire logic        o_so,
	input wire logic        o_so_oe,
	input wire logic [7:0]  o_status,
	input wire logic        o_arr_wr_req,
	input wire logic        o_id_wr_req,
	input wire logic [15:0] o_addr,
	input wire logic        o_addr_prot
);
	logic exp_prot;
	assign exp_prot = o_status[3:2] == 2'b11
		|| (o_status[3:2] == 2'b10 && o_addr >= 16'h2000)
		|| (o_status[3:2] == 2'b01 && o_addr >= 16'h3000);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	a_reset_clear: assert property (@(posedge i_ref_clk) disable iff (1'b0)
		i_reset |=> o_status == 8'h00) else $error("status not cleared");
	a_busy_ones: assert property (o_status[0] |-> o_status == 8'hFF)
		else $error("busy status not all ones");
	a_idle_zero: assert property (!o_status[0] |-> o_status[6:4] == 3'b000)
		else $error("spare bits set while idle");
	a_latch_guard: assert property (!o_status[0] && !$past(o_status[0])
		&& !$past(o_status[1]) |-> $stable({o_status[7], o_status[3:2]}))
		else $error("status changed with latch clear");
	a_wr_latch: assert property (o_arr_wr_req |-> o_status[1])
		else $error("array write without latch");
	a_wr_busy: assert property ($rose(o_arr_wr_req)
		|-> ##[0:4] o_status == 8'hFF) else $error("write did not go busy");
	a_id_low: assert property (o_id_wr_req |-> ##[0:2] !o_addr[10])
		else $error("ID write with lock address");
	a_prot_map: assert property ($stable(o_addr) && $stable(o_status)
		&& !o_status[0] && o_addr <= 16'h3FFF |-> o_addr_prot == exp_prot)
		else $error("protect flag wrong");
	a_oe_idle: assert property (i_cs_n && $past(i_cs_n) |-> !o_so_oe)
		else $error("output driven while deselected");
endmodule // sesp_core_properties
bind sesp_core sesp_core_properties chk_u (.i_ref_clk(i_ref_clk),
	.i_reset(i_reset), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si),
	.i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe(o_so_oe), .o_status(o_status),
	.o_arr_wr_req(o_arr_wr_req), .o_id_wr_req(o_id_wr_req),
	.o_addr(o_addr), .o_addr_prot(o_addr_prot));

// ==== tb/sesp_master.sv ====
// Serial master model that frames bytes to the front end
`timescale 1ns/1ps
module sesp_master (
	input  wire logic i_ref_clk,
	input  wire logic i_so,
	output logic      o_sck,
	output logic      o_cs_n,
	output logic      o_si
);
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
	end
	task automatic xfer(input logic [39:0] d, input int n,
		output logic [7:0] rx);
		rx = 8'h00;
		@(negedge i_ref_clk);
		o_cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			o_si = d[i];
			#80 o_sck = 1'b1;
			rx = {rx[6:0], i_so};
			#80 o_sck = 1'b0;
		end
		o_cs_n = 1'b1;
		// Released line shows the inverse so stale data never matches
		o_si = ~o_si;
	endtask
endmodule // sesp_master

// ==== tb/test_sesp_core.sv ====
// Self-checking bench for the status and opcode front end
`timescale 1ns/1ps
module test_sesp_core;
	logic        i_ref_clk, i_reset, i_wp_n, sck, cs_n, si, so;
	logic        so_oe, arr_wr, id_wr, prot;
	logic [7:0]  status, rx;
	logic [15:0] addr;
	logic [15:0] ad [3] = '{16'h1FFF, 16'h2000, 16'h3000};
	int          n_fail, checks_done, n_arr, n_id;
	initial begin
		i_ref_clk = 1'b0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end
	sesp_core dut_u (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_sck(sck),
		.i_cs_n(cs_n), .i_si(si), .i_wp_n(i_wp_n), .o_so(so),
		.o_so_oe(so_oe), .o_status(status), .o_arr_wr_req(arr_wr),
		.o_id_wr_req(id_wr), .o_addr(addr), .o_addr_prot(prot));
	sesp_master mst_u (.i_ref_clk(i_ref_clk), .i_so(so), .o_sck(sck),
		.o_cs_n(cs_n), .o_si(si));
	always @(posedge arr_wr) n_arr++;
	always @(posedge id_wr) n_id++;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		if (n_fail == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic go(input logic [39:0] d, input int n);
		mst_u.xfer(d, n, rx);
		repeat (10) @(negedge i_ref_clk);
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		while (status[0] !== 1'b0 && k < 400) begin
			@(negedge i_ref_clk);
			k++;
		end
		if (k == 400) begin
			n_fail++;
			finish_test();
		end
	endtask
	task automatic status_write_cmd(input logic [7:0] v);
		go(40'h06, 8);
		go({24'h0, 8'h01, v}, 16);
		wait_idle();
	endtask
	initial begin
		i_reset = 1'b1;
		i_wp_n = 1'b1;
		{n_fail, checks_done, n_arr, n_id} = '0;
		repeat (6) @(negedge i_ref_clk);
		i_reset = 1'b0;
		repeat (5) @(negedge i_ref_clk);
		chk(status, 8'h00);
		go(40'h018C, 16);
		chk(status, 8'h00);
		go(40'h0E, 8);
		chk(status, 8'h02);
		go(40'h0500, 16);
		chk(rx, 8'h02);
		go(40'h07, 8);
		chk(status, 8'h02);
		go(40'h0C, 8);
		chk(status, 8'h00);
		for (int b = 0; b < 4; b++) begin
			status_write_cmd({4'h0, b[1:0], 2'b00});
			chk(status, {4'h0, b[1:0], 2'b00});
			for (int j = 0; j < 3; j++) begin
				go({8'h03, ad[j], 8'h00}, 32);
				chk(addr, ad[j]);
				chk(prot, b == 3 || (b == 2 && j > 0) || (b == 1 && j == 2));
			end
		end
		status_write_cmd(8'h00);
		go(40'h06, 8);
		go(40'h02_1234_A5, 32);
		chk(status, 8'hFF);
		go(40'h0500, 16);
		chk(rx, 8'hFF);
		go(40'h06, 8);
		wait_idle();
		chk(status, 8'h00);
		chk(n_arr, 1);
		go(40'h06, 8);
		go(40'h82_0400_55, 32);
		chk(n_id, 0);
		go(40'h8A_0000_55, 32);
		chk(n_id, 1);
		wait_idle();
		status_write_cmd(8'h80);
		chk(status, 8'h80);
		i_wp_n = 1'b0;
		go(40'h06, 8);
		go(40'h0100, 16);
		wait_idle();
		chk(status & 8'h8C, 8'h80);
		i_wp_n = 1'b1;
		repeat (6) @(negedge i_ref_clk);
		status_write_cmd(8'h00);
		chk(status, 8'h00);
		finish_test();
	end
endmodule // test_sesp_core
